// ---- core/rss_lanes.sv ----
// Element-wise datapath: rounding logical shift and four saturating subtracts.
// Assumes operands are stable when the top samples the result.
`timescale 1ns/1ps
module rss_lanes #(
  parameter int VLEN = 128
) (
  // Operand and result carrier
  rss_lane_if.lanes lif
);
  // Shift right logical with rounding on one element of width b
  function automatic logic [63:0] shr_round(input logic [63:0] v, input int b,
                                             input logic [5:0] n);
    logic [63:0] m;
    logic [63:0] r;
    m = (b == 64) ? 64'hFFFF_FFFF_FFFF_FFFF : ((64'h0000_0000_0000_0001 << b) - 64'h1);
    r = v & m;
    if (n == 6'h00)
    begin
      shr_round = r;
    end
    else
    begin
      shr_round = ((r >> n) + {63'h0, r[n-1]}) & m;
    end
  endfunction

  // Saturating subtract on one element of width b, kind chosen by op
  function automatic logic [63:0] sat_sub(input logic [63:0] a, input logic [63:0] c,
                                          input int b, input rss_pkg::rss_op_t op);
    logic [65:0] ea;
    logic [65:0] ec;
    logic [65:0] d;
    logic [65:0] m;
    logic [65:0] smax;
    logic [65:0] smin;
    m = (66'h1 << b) - 66'h1;
    smax = m >> 1;
    smin = ~smax;
    ea = {2'h0, a} & m;
    ec = {2'h0, c} & m;
    // Sign-extend where the operand is signed
    if ((op == rss_pkg::RSS_OP_SUBS_S) && a[b-1])
      ea = ea | ~m;
    if ((op == rss_pkg::RSS_OP_SUBS_S || op == rss_pkg::RSS_OP_SUBSUS_U) && c[b-1])
      ec = ec | ~m;
    d = ea - ec;
    sat_sub = 64'h0;
    unique case (op)
      rss_pkg::RSS_OP_SUBS_U, rss_pkg::RSS_OP_SUBSUS_U:
      begin
        if (d[65])
          sat_sub = 64'h0;
        else if ((d & ~m) != 66'h0)
          sat_sub = m[63:0];
        else
          sat_sub = d[63:0];
      end
      default:
      begin
        // Signed clamp for SUBS_S and SUBSUU_S
        if (!d[65] && $signed(d) > $signed(smax))
          sat_sub = smax[63:0] & m[63:0];
        else if (d[65] && $signed(d) < $signed(smin))
          sat_sub = smin[63:0] & m[63:0];
        else
          sat_sub = d[63:0] & m[63:0];
      end
    endcase
  endfunction

  // One lane per byte position; each format uses every 1st/2nd/4th/8th lane
  genvar g;
  generate
    for (g = 0; g < VLEN / 8; g++)
    begin : g_lane
      logic [63:0] a_e;
      logic [63:0] b_e;
      logic [63:0] r_b;
      logic [63:0] r_h;
      logic [63:0] r_w;
      logic [63:0] r_d;
      // Per-format results for the element starting at this byte
      always_comb
      begin
        a_e = '0;
        b_e = '0;
        r_b = '0;
        r_h = '0;
        r_w = '0;
        r_d = '0;
        a_e[7:0] = lif.src_a[8*g +: 8];
        b_e[7:0] = lif.src_b[8*g +: 8];
        r_b = (lif.op == rss_pkg::RSS_OP_SHR_ROUND) ? shr_round(a_e, 8, {3'h0, lif.shamt[2:0]})
              : sat_sub(a_e, b_e, 8, lif.op);
        if (g % 2 == 0 && 8*g + 16 <= VLEN)
        begin
          a_e[15:0] = lif.src_a[8*g +: 16];
          b_e[15:0] = lif.src_b[8*g +: 16];
          r_h = (lif.op == rss_pkg::RSS_OP_SHR_ROUND)
                ? shr_round(a_e, 16, {2'h0, lif.shamt[3:0]}) : sat_sub(a_e, b_e, 16, lif.op);
        end
        if (g % 4 == 0 && 8*g + 32 <= VLEN)
        begin
          a_e[31:0] = lif.src_a[8*g +: 32];
          b_e[31:0] = lif.src_b[8*g +: 32];
          r_w = (lif.op == rss_pkg::RSS_OP_SHR_ROUND)
                ? shr_round(a_e, 32, {1'h0, lif.shamt[4:0]}) : sat_sub(a_e, b_e, 32, lif.op);
        end
        if (g % 8 == 0 && 8*g + 64 <= VLEN)
        begin
          a_e = lif.src_a[8*g +: 64];
          b_e = lif.src_b[8*g +: 64];
          r_d = (lif.op == rss_pkg::RSS_OP_SHR_ROUND)
                ? shr_round(a_e, 64, lif.shamt) : sat_sub(a_e, b_e, 64, lif.op);
        end
      end
      // Pick this byte of the result by element format
      always_comb
      begin
        unique case (lif.fmt)
          rss_pkg::FMT_BYTE: lif.result[8*g +: 8] = r_b[7:0];
          rss_pkg::FMT_HALF: lif.result[8*g +: 8] = g_lane[g - g % 2].r_h[8*(g%2) +: 8];
          rss_pkg::FMT_WORD: lif.result[8*g +: 8] = g_lane[g - g % 4].r_w[8*(g%4) +: 8];
          default: lif.result[8*g +: 8] = g_lane[g - g % 8].r_d[8*(g%8) +: 8];
        endcase
      end
    end
  endgenerate
endmodule

// ---- core/rss_unit.sv ----
// Top of the SIMD slice: issue, result register, store request and exception report.
// Assumes the host core decodes and gates reserved/disabled instructions.
`timescale 1ns/1ps
module rss_unit #(
  parameter int VLEN = rss_pkg::VLEN_DEFAULT,
  parameter int AW = rss_pkg::ADDR_DEFAULT
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Issue from host core
  input wire logic issue_valid,
  output logic issue_ready,
  input wire rss_pkg::rss_op_t issue_op,
  input wire logic [1:0] element_format,
  input wire logic [5:0] shift_imm,
  input wire logic [rss_pkg::OFFSET_BITS-1:0] scaled_offset_field,
  input wire logic [AW-1:0] base_gpr,
  input wire logic [VLEN-1:0] first_source_vector,
  input wire logic [VLEN-1:0] second_source_vector,
  // Result write-back
  output logic wb_valid,
  output logic [VLEN-1:0] dest_vector,
  // Store request to load-store path
  output logic st_valid,
  input wire logic st_ready,
  output logic [AW-1:0] st_addr,
  output logic [VLEN-1:0] st_data,
  output logic [1:0] st_format,
  output logic st_elem_aligned,
  // Fault answer from load-store path
  input wire logic lsu_tlb_fault,
  input wire logic lsu_addr_error,
  output logic exc_valid,
  output logic exc_tlb,
  output logic exc_addr
);
  // Refuse shapes the lane array cannot serve
  initial
  begin
    if (VLEN < 64 || VLEN % 64 != 0)
      $error("VLEN must be a positive multiple of 64");
    if (AW < rss_pkg::OFFSET_BITS + 3)
      $error("AW too narrow for scaled offset");
  end

  // Unit state
  rss_pkg::rss_state_t state_q;
  // Lane carrier
  rss_lane_if #(.VLEN(VLEN)) lif ();
  // Accept strobe
  logic take;
  // Scaled offset and effective address
  logic [AW-1:0] off_ext;
  logic [AW-1:0] ea;
  // Low-bit alignment mask per format
  logic [AW-1:0] amask;

  assign lif.op = issue_op;
  assign lif.fmt = element_format;
  assign lif.shamt = shift_imm;
  assign lif.src_a = first_source_vector;
  assign lif.src_b = second_source_vector;

  // Lane array
  rss_lanes #(.VLEN(VLEN)) u_lanes (
    .lif(lif)
  );

  // Accept only while idle; host keeps reserved/disabled ops away
  assign take = issue_valid && issue_ready;
  // Sign-extend then scale the offset by element size
  assign off_ext = AW'($signed(scaled_offset_field)) << element_format;
  // Base plus scaled offset, any value accepted
  assign ea = base_gpr + off_ext;
  assign amask = (AW'(1) << element_format) - AW'(1);

  // Issue handshake state: hold while a store waits for the load-store path
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= rss_pkg::RSS_ST_IDLE;
      issue_ready <= 1'b1;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        rss_pkg::RSS_ST_IDLE:
        begin
          if (take && issue_op == rss_pkg::RSS_OP_STORE)
          begin
            state_q <= rss_pkg::RSS_ST_HOLD;
            issue_ready <= 1'b0;
          end
        end
        rss_pkg::RSS_ST_HOLD:
        begin
          // Done on handshake or fault answer
          if ((st_valid && st_ready) || lsu_tlb_fault || lsu_addr_error)
          begin
            state_q <= rss_pkg::RSS_ST_IDLE;
            issue_ready <= 1'b1;
          end
        end
        default:
        begin
          state_q <= rss_pkg::RSS_ST_IDLE;
          issue_ready <= 1'b1;
        end
      endcase
    end
  end

  // Arithmetic write-back: all lanes in one register update
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_valid <= rss_pkg::RESET_BIT;
      dest_vector <= '0;
    end
    else if (clk_en)
    begin
      wb_valid <= take && issue_op != rss_pkg::RSS_OP_STORE;
      if (take && issue_op != rss_pkg::RSS_OP_STORE)
        dest_vector <= lif.result;
    end
  end

  // Store request: whole register, address, format, alignment flag
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_valid <= rss_pkg::RESET_BIT;
      st_addr <= '0;
      st_data <= '0;
      st_format <= rss_pkg::FMT_BYTE;
      st_elem_aligned <= rss_pkg::RESET_BIT;
    end
    else if (clk_en)
    begin
      if (take && issue_op == rss_pkg::RSS_OP_STORE)
      begin
        st_valid <= 1'b1;
        st_addr <= ea;
        st_data <= first_source_vector;
        st_format <= element_format;
        st_elem_aligned <= (ea & amask) == '0;
      end
      else if (st_ready || lsu_tlb_fault || lsu_addr_error)
        st_valid <= 1'b0;
    end
  end

  // Fault report: only stores raise address-dependent exceptions
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      exc_valid <= rss_pkg::RESET_BIT;
      exc_tlb <= rss_pkg::RESET_BIT;
      exc_addr <= rss_pkg::RESET_BIT;
    end
    else if (clk_en)
    begin
      exc_valid <= st_valid && (lsu_tlb_fault || lsu_addr_error);
      exc_tlb <= st_valid && lsu_tlb_fault;
      exc_addr <= st_valid && lsu_addr_error;
    end
  end
endmodule

// ---- dv/rss_lsu_model.sv ----
// Load-store path stand-in: answers each store after a set wait.
// Assumes requests hold until answered; fault_sel picks the answer.
`timescale 1ns/1ps
module rss_lsu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench controls
  input wire logic [3:0] wait_cyc,
  input wire logic [1:0] fault_sel,
  // Store handshake
  input wire logic st_valid,
  output logic st_ready,
  output logic lsu_tlb_fault,
  output logic lsu_addr_error
);
  logic [3:0] cnt_q; // Cycles the request has waited
  // Count only while a request stands
  always_ff @(posedge clk)
  begin
    if (!rst_n || !st_valid)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
  // Answer once the wait is spent, never earlier
  wire logic due = st_valid && cnt_q == wait_cyc;
  assign st_ready = due && fault_sel == 2'h0;
  assign lsu_tlb_fault = due && fault_sel == 2'h1;
  assign lsu_addr_error = due && fault_sel == 2'h2;
endmodule

// ---- dv/rss_unit_asserts.sv ----
// Port checker for the SIMD slice: write-back, store request, faults.
// Assumes one clock with a synchronous active-low reset.
`timescale 1ns/1ps
module rss_unit_asserts #(
  parameter int VLEN = 128,
  parameter int AW = 64
) (
  // Clock and issue
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire rss_pkg::rss_op_t issue_op,
  input wire logic [1:0] element_format,
  input wire logic [9:0] scaled_offset_field,
  input wire logic [AW-1:0] base_gpr,
  input wire logic [VLEN-1:0] first_source_vector,
  // Results and store
  input wire logic wb_valid,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire logic [AW-1:0] st_addr,
  input wire logic [VLEN-1:0] st_data,
  input wire logic [1:0] st_format,
  input wire logic st_elem_aligned,
  // Faults
  input wire logic lsu_tlb_fault,
  input wire logic lsu_addr_error,
  input wire logic exc_valid,
  input wire logic exc_tlb,
  input wire logic exc_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Issue taken, store kind, fault answered
  wire logic take = clk_en && issue_valid && issue_ready;
  wire logic is_st = issue_op == rss_pkg::RSS_OP_STORE;
  wire logic flt = lsu_tlb_fault || lsu_addr_error;
  sequence s_st_take; take && is_st; endsequence
  sequence s_st_wait; st_valid && !st_ready && !flt; endsequence
  a_wb_arith:
    assert property (take && !is_st |=> wb_valid) else $error("no write-back");
  a_wb_cause:
    assert property (wb_valid |-> $past(take && !is_st)) else $error("stray write-back");
  a_st_fields:
    assert property (s_st_take |=> st_valid && !issue_ready && st_format == $past(element_format)
      && st_data == $past(first_source_vector)) else $error("bad store request");
  a_st_addr:
    assert property (s_st_take |=> st_addr == $past(base_gpr
      + ({{(AW-10){scaled_offset_field[9]}}, scaled_offset_field} << element_format)))
      else $error("bad store address");
  a_st_hold:
    assert property (s_st_wait |=> st_valid && $stable(st_addr) && $stable(st_data))
      else $error("store dropped");
  a_st_end:
    assert property (st_valid && (st_ready || flt) |=> !st_valid && issue_ready)
      else $error("store not retired");
  a_st_align:
    assert property (st_valid |-> st_elem_aligned
      == ((st_addr[2:0] & ((3'h1 << st_format) - 3'h1)) == 3'h0)) else $error("bad align flag");
  a_exc_fault:
    assert property (st_valid && flt |=> exc_valid && exc_tlb == $past(lsu_tlb_fault)
      && exc_addr == $past(lsu_addr_error)) else $error("fault not reported");
  a_exc_cause:
    assert property (exc_valid |-> $past(st_valid && flt)) else $error("value exception");
endmodule
bind rss_unit rss_unit_asserts #(.VLEN(VLEN), .AW(AW)) u_chk (.clk, .rst_n, .clk_en,
  .issue_valid, .issue_ready, .issue_op, .element_format, .scaled_offset_field, .base_gpr,
  .first_source_vector, .wb_valid, .st_valid, .st_ready, .st_addr, .st_data, .st_format,
  .st_elem_aligned, .lsu_tlb_fault, .lsu_addr_error, .exc_valid, .exc_tlb, .exc_addr);

// ---- dv/tb_top.sv ----
// Self-checking bench for the SIMD slice: lane arithmetic, stores, reset.
// Assumes the load-store stand-in answers stores as the bench sets it.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  typedef struct {rss_pkg::rss_op_t op; logic [1:0] f; logic [5:0] s;
    logic [63:0] a, b, e;} rss_row_t;
  // Stimulus and observed ports
  logic clk = 0, rst_n = 0, clk_en = 1, issue_valid = 0, issue_ready, wb_valid;
  rss_pkg::rss_op_t issue_op = rss_pkg::RSS_OP_STORE;
  logic [1:0] element_format = 2'h0, st_format, fault_sel = 2'h0;
  logic [5:0] shift_imm = 6'h0;
  logic [9:0] scaled_offset_field = 10'h0;
  logic [3:0] wait_cyc = 4'h0;
  logic [63:0] base_gpr = 64'h0, st_addr;
  logic [127:0] first_source_vector = '0, second_source_vector = '0, dest_vector, st_data;
  logic st_valid, st_ready, st_elem_aligned, lsu_tlb_fault, lsu_addr_error;
  logic exc_valid, exc_tlb, exc_addr;
  int n_errors = 0, comparisons = 0;
  rss_row_t rows[$];
  always #4 clk = ~clk;
  rss_unit dut (.clk, .rst_n, .clk_en, .issue_valid, .issue_ready, .issue_op, .element_format,
    .shift_imm, .scaled_offset_field, .base_gpr, .first_source_vector, .second_source_vector,
    .wb_valid, .dest_vector, .st_valid, .st_ready, .st_addr, .st_data, .st_format,
    .st_elem_aligned, .lsu_tlb_fault, .lsu_addr_error, .exc_valid, .exc_tlb, .exc_addr);
  rss_lsu_model lsu (.clk, .rst_n, .wait_cyc, .fault_sel, .st_valid, .st_ready, .lsu_tlb_fault,
    .lsu_addr_error);
  // One row: op, format, shift, 64-bit halves of both sources and result
  task automatic add(rss_pkg::rss_op_t o, logic [1:0] f, logic [5:0] s, logic [63:0] a, b, e);
    rows.push_back(rss_row_t'{o, f, s, a, b, e});
  endtask
  // One store; answer after w cycles, fs 0 ready, 1 tlb, 2 address
  task automatic store(logic [1:0] f, logic [9:0] o, logic [63:0] b, ea, logic al,
    logic [3:0] w, logic [1:0] fs);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_op <= rss_pkg::RSS_OP_STORE;
    element_format <= f;
    scaled_offset_field <= o;
    base_gpr <= b;
    first_source_vector <= {b, ~b};
    wait_cyc <= w;
    fault_sel <= fs;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    `CHK("st_valid", 1'b1, st_valid)
    `CHK("issue_ready", 1'b0, issue_ready)
    `CHK("st_addr", ea, st_addr)
    `CHK("st_aligned", al, st_elem_aligned)
    `CHK("st_data", {b, ~b}, st_data)
    repeat (w) @(posedge clk);
    @(posedge clk);
    #1;
    `CHK("st_done", 2'b01, {st_valid, issue_ready})
    `CHK("exc", {fs != 2'h0, fs == 2'h1, fs == 2'h2}, {exc_valid, exc_tlb, exc_addr})
  endtask
  task automatic give_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial
  begin
    #20000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    add(rss_pkg::RSS_OP_SHR_ROUND, 0, 0, 64'h9f00_ff7f_0180_55aa, 0, 64'h9f00_ff7f_0180_55aa);
    add(rss_pkg::RSS_OP_SHR_ROUND, 0, 3, 64'h9f9f_9f9f_0707_0404, 0, 64'h1414_1414_0101_0101);
    add(rss_pkg::RSS_OP_SHR_ROUND, 1, 15, 64'hffff_8000_4000_0001, 0, 64'h0002_0001_0001_0000);
    add(rss_pkg::RSS_OP_SHR_ROUND, 3, 63, 64'hc000_0000_0000_0000, 0, 64'h0002);
    add(rss_pkg::RSS_OP_SUBS_S, 0, 0, 64'h0500_0000_8000_7f7f, 64'h0300_0000_0100_ff81,
      64'h0200_0000_8000_7f7f);
    add(rss_pkg::RSS_OP_SUBS_S, 2, 0, 64'h8000_0000_7fff_ffff, 64'h0000_0001_ffff_ffff,
      64'h8000_0000_7fff_ffff);
    add(rss_pkg::RSS_OP_SUBS_U, 1, 0, 64'h0005_ffff_0000_1234, 64'h0007_0001_0001_0234,
      64'h0000_fffe_0000_1000);
    add(rss_pkg::RSS_OP_SUBSUS_U, 0, 0, 64'hf001_8000, 64'h8002_7fff, 64'hff00_0101);
    add(rss_pkg::RSS_OP_SUBSUU_S, 0, 0, 64'hff00_1020, 64'h00ff_2010, 64'h7f80_f010);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Rows issue back to back; each result lands one cycle later
    for (int i = 0; i <= rows.size(); i++)
    begin
      @(posedge clk);
      issue_valid <= i < rows.size();
      if (i < rows.size())
      begin
        issue_op <= rows[i].op;
        element_format <= rows[i].f;
        shift_imm <= rows[i].s;
        first_source_vector <= {2{rows[i].a}};
        second_source_vector <= {2{rows[i].b}};
      end
      #1;
      if (i > 0)
      begin
        `CHK("wb_valid", 1'b1, wb_valid)
        `CHK("dest", {2{rows[i-1].e}}, dest_vector)
      end
    end
    $display("arith rows done");
    store(2'h2, 10'h3ff, 64'h1000, 64'h0ffc, 1'b1, 4'h3, 2'h0);
    store(2'h3, 10'h002, 64'h1003, 64'h1013, 1'b0, 4'h0, 2'h0);
    store(2'h0, 10'h200, 64'h1000, 64'h0e00, 1'b1, 4'h1, 2'h1);
    store(2'h1, 10'h1ff, 64'h0001, 64'h03ff, 1'b0, 4'h0, 2'h2);
    $display("store cases done");
    // Mid-run reset clears the held result; reset driven on the edge
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Offer an op at once with the enable low: it must be ignored
    clk_en <= 1'b0;
    issue_valid <= 1'b1;
    issue_op <= rss_pkg::RSS_OP_SUBS_U;
    element_format <= 2'h3;
    first_source_vector <= {2{64'h0000_0000_0000_0009}};
    second_source_vector <= {2{64'h0000_0000_0000_0002}};
    #1;
    `CHK("reset", {1'b1, 1'b0, 1'b0, 128'h0}, {issue_ready, wb_valid, st_valid, dest_vector})
    $display("reset case done");
    // Frozen edge: nothing taken, nothing changes
    @(posedge clk);
    clk_en <= 1'b1;
    #1;
    `CHK("frozen", {1'b0, 128'h0}, {wb_valid, dest_vector})
    // Enable back: the held offer is taken, doubleword unsigned subtract
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
    `CHK("unfrozen", {1'b1, {2{64'h0000_0000_0000_0007}}}, {wb_valid, dest_vector})
    $display("enable case done");
    give_verdict();
  end
endmodule

// ---- pkg/rss_lane_if.sv ----
// Interface carrying lane operands and results between the top and the lane array.
// Assumes both ends share one clock domain; purely combinational signals.
`timescale 1ns/1ps
interface rss_lane_if #(parameter int VLEN = 128);
  // Operation select
  rss_pkg::rss_op_t op;
  // Element format
  logic [1:0] fmt;
  // Immediate shift amount
  logic [5:0] shamt;
  // Source vectors
  logic [VLEN-1:0] src_a;
  logic [VLEN-1:0] src_b;
  // Lane results
  logic [VLEN-1:0] result;
  modport top (output op, fmt, shamt, src_a, src_b, input result);
  modport lanes (input op, fmt, shamt, src_a, src_b, output result);
endinterface

// ---- pkg/rss_pkg.sv ----
// Shared constants and types for the SIMD round-shift, sat-subtract and store slice.
// Assumes the host core supplies decoded operations and operands each cycle.
package rss_pkg;
  // Element format codes
  localparam logic [1:0] FMT_BYTE = 2'h0;
  localparam logic [1:0] FMT_HALF = 2'h1;
  localparam logic [1:0] FMT_WORD = 2'h2;
  localparam logic [1:0] FMT_DBL = 2'h3;
  // Offset field width
  localparam int OFFSET_BITS = 10;
  // Default vector length in bits
  localparam int VLEN_DEFAULT = 128;
  // Default address width
  localparam int ADDR_DEFAULT = 64;
  // Reset value of one-bit valid and flag outputs
  localparam logic RESET_BIT = 1'b0;
  // Operation codes, one-hot
  typedef enum logic [5:0] {
    RSS_OP_SHR_ROUND = 6'h01,
    RSS_OP_STORE = 6'h02,
    RSS_OP_SUBS_S = 6'h04,
    RSS_OP_SUBS_U = 6'h08,
    RSS_OP_SUBSUS_U = 6'h10,
    RSS_OP_SUBSUU_S = 6'h20
  } rss_op_t;
  // Unit states, one-hot
  typedef enum logic [1:0] {
    RSS_ST_IDLE = 2'h1,
    RSS_ST_HOLD = 2'h2
  } rss_state_t;
endpackage
